/* File: rtl/qdec_pkg.sv */
// constants, field layouts and carrier types for the quadrature decoder bank
// assumes one 20 MHz core clock and an AHB-Lite register bus
package qdec_pkg;
    // ==========================================================
    // sizes
    localparam int NUM_DEC = 8;
    localparam int NUM_PINS = 16;
    localparam int SRC_W = 4;
    localparam int CNT_W = 32;
    localparam logic [3:0] NUM_SLOTS = 4'h8;
    // clock period, used by software to turn period counts into seconds
    localparam int CLK_PERIOD_NS = 50;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_INT_STATUS = 8'h00;
    localparam logic [7:0] OFS_INT_MASK = 8'h04;
    localparam logic [7:0] OFS_COMMAND = 8'h08;
    localparam logic [7:0] OFS_CMD_STATUS = 8'h0C;
    localparam logic [7:0] OFS_SELECT = 8'h10;
    localparam logic [7:0] OFS_COUNT = 8'h14;
    localparam logic [7:0] OFS_PERIOD = 8'h18;
    localparam logic [7:0] OFS_FLAGS = 8'h1C;
    localparam logic [7:0] OFS_HALT_TIMEOUT = 8'h20;
    // ==========================================================
    // command register fields
    localparam int CMD_SLOT_LSB = 0;
    localparam int CMD_OPEN_BIT = 8;
    localparam int CMD_CLOSE_BIT = 9;
    localparam int CMD_START_BIT = 10;
    localparam int CMD_STOP_BIT = 11;
    localparam int CMD_RESET_BIT = 12;
    localparam int CMD_POL_BIT = 16;
    localparam int CMD_SRC_A_LSB = 20;
    localparam int CMD_SRC_B_LSB = 24;
    // interrupt status: stall events in low bits, command error above
    localparam int INT_ERR_BIT = 8;
    // ==========================================================
    // reset values
    localparam logic [31:0] HALT_TIMEOUT_RST = 32'h0000_0000;
    localparam logic [8:0] INT_MASK_RST = 9'h000;
    localparam logic [3:0] SELECT_RST = 4'h0;
    // observable state of one decoder
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] period;
        logic dir;
        logic stalled;
    } dec_state_t;
endpackage : qdec_pkg

/* File: rtl/qdec_sync.sv */
// two flip-flop synchroniser bank for asynchronous pins
// assumes each bit is an independent level
`timescale 1ns/1ps
module qdec_sync #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // asynchronous pins and synchronised copy
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg; // first stage, read only by second stage
    logic [WIDTH-1:0] sync_reg; // second stage

    // ==========================================================
    // two stages, no logic between them
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule : qdec_sync

/* File: rtl/qdec_channel.sv */
// one 4x quadrature decoder with period and stall tracking
// assumes phase inputs already synchronised to the core clock
`timescale 1ns/1ps
module qdec_channel (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // synchronised phases
    input wire logic i_phase_a,
    input wire logic i_phase_b,
    // control
    input wire logic i_run,
    input wire logic i_clear,
    input wire logic i_polarity,
    input wire logic [31:0] i_halt_timeout,
    // state
    output qdec_pkg::dec_state_t o_state,
    output logic o_stall_event
);
    logic prev_a_reg; // last sampled phases
    logic prev_b_reg;
    logic [31:0] gap_reg; // cycles since last step
    qdec_pkg::dec_state_t st_reg;
    qdec_pkg::dec_state_t st_next;

    // ==========================================================
    // edge classification
    wire chg_a = i_phase_a ^ prev_a_reg;
    wire chg_b = i_phase_b ^ prev_b_reg;
    wire one_chg = chg_a ^ chg_b;
    // each single edge steps while running
    wire step = i_run & one_chg;
    // a leads b when the changed phase now differs / agrees accordingly
    wire a_lead = chg_a ? (i_phase_a ^ i_phase_b) : ~(i_phase_a ^ i_phase_b);
    wire up = i_polarity ? a_lead : ~a_lead;
    wire gap_full = &gap_reg;
    // timeout of zero disables stall detection
    wire halt_hit = i_run & (i_halt_timeout != 32'h0000_0000) & (gap_reg >= i_halt_timeout);

    // ==========================================================
    // next state
    always_comb begin
        st_next = st_reg;
        if (step) begin
            st_next.count = up ? st_reg.count + 32'h0000_0001 : st_reg.count - 32'h0000_0001;
            st_next.dir = up;
            st_next.period = gap_full ? gap_reg : gap_reg + 32'h0000_0001;
            st_next.stalled = 1'b0;
        end else if (halt_hit) begin
            st_next.stalled = 1'b1;
        end
        // reset zeroes count regardless of run
        if (i_clear) begin
            st_next.count = '0;
        end
    end

    // ==========================================================
    // registers; phases tracked while stopped so a restart sees no false edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_a_reg <= 1'b0;
            prev_b_reg <= 1'b0;
            gap_reg <= '0;
            st_reg <= '0;
        end else begin
            prev_a_reg <= i_phase_a;
            prev_b_reg <= i_phase_b;
            st_reg <= st_next;
            if (step) begin
                gap_reg <= '0;
            end else if (i_run && !gap_full) begin
                gap_reg <= gap_reg + 32'h0000_0001;
            end
        end
    end

    assign o_state = st_reg;
    assign o_stall_event = halt_hit & ~st_reg.stalled & ~step;
endmodule : qdec_channel

/* File: rtl/quad_decoder_4x.sv */
// bank of eight 4x quadrature decoders behind an AHB-Lite slave
// assumes a single AHB-Lite master, word transfers, and
// encoder phases arriving asynchronously on pins
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module quad_decoder_4x #(
    parameter int NUM_PINS = qdec_pkg::NUM_PINS
) (
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    // ahb-lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    // encoder phase pins
    input wire logic [NUM_PINS-1:0] I_PHASE_PINS,
    // interrupt
    output logic O_IRQ
);
    localparam int ND = qdec_pkg::NUM_DEC;
    localparam int SW = qdec_pkg::SRC_W;

    // ==========================================================
    // pin synchronisation
    logic [NUM_PINS-1:0] pins_sync; // pins in core clock domain

    qdec_sync #(
        .WIDTH(NUM_PINS)
    ) u_sync (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .i_async(I_PHASE_PINS),
        .o_sync(pins_sync)
    );

    // ==========================================================
    // ahb address phase capture
    logic wr_pend_reg; // write data phase pending
    logic [7:0] wr_addr_reg; // byte offset of pending write
    logic [31:0] hrdata_reg; // read data, loaded at address phase

    // a transfer is taken when selected, active and the bus is ready
    wire take = I_HSEL & I_HTRANS[1] & I_HREADY;
    wire take_rd = take & ~I_HWRITE;
    wire take_wr = take & I_HWRITE;
    wire [7:0] rd_ofs = I_HADDR[7:0];
    // upper address bits outside the block's window read as unmapped
    wire in_win = (I_HADDR[31:8] == 24'h000000);

    // write strobes for the data phase
    wire wr_int_status = wr_pend_reg & (wr_addr_reg == qdec_pkg::OFS_INT_STATUS);
    wire wr_int_mask = wr_pend_reg & (wr_addr_reg == qdec_pkg::OFS_INT_MASK);
    wire wr_command = wr_pend_reg & (wr_addr_reg == qdec_pkg::OFS_COMMAND);
    wire wr_select = wr_pend_reg & (wr_addr_reg == qdec_pkg::OFS_SELECT);
    wire wr_timeout = wr_pend_reg & (wr_addr_reg == qdec_pkg::OFS_HALT_TIMEOUT);

    // ==========================================================
    // per-slot control state
    logic [ND-1:0] reserved_reg; // slot held by software
    logic [ND-1:0] run_reg; // slot decoding
    logic [ND-1:0] pol_reg; // count sense per slot
    logic [SW-1:0] src_a_reg [ND]; // phase_a_input source
    logic [SW-1:0] src_b_reg [ND]; // phase_b_input source
    logic [31:0] halt_timeout_setting_reg [ND];
    logic [3:0] select_reg; // decoder_handle for reads
    logic cmd_err_reg; // last command, select or timeout write failed
    logic [8:0] int_status_reg;
    logic [8:0] int_mask_reg;

    // ==========================================================
    // command decode, from the write data
    wire [3:0] decoder_slot_number = I_HWDATA[qdec_pkg::CMD_SLOT_LSB +: 4];
    wire [2:0] slot = decoder_slot_number[2:0];
    wire slot_ok = decoder_slot_number < qdec_pkg::NUM_SLOTS;
    wire sel_ok = select_reg < qdec_pkg::NUM_SLOTS;
    wire new_sel_ok = I_HWDATA[3:0] < qdec_pkg::NUM_SLOTS;
    wire c_open = I_HWDATA[qdec_pkg::CMD_OPEN_BIT];
    wire c_close = I_HWDATA[qdec_pkg::CMD_CLOSE_BIT];
    wire c_start = I_HWDATA[qdec_pkg::CMD_START_BIT];
    wire c_stop = I_HWDATA[qdec_pkg::CMD_STOP_BIT];
    wire c_reset = I_HWDATA[qdec_pkg::CMD_RESET_BIT];
    wire c_pol = I_HWDATA[qdec_pkg::CMD_POL_BIT];
    wire [SW-1:0] c_src_a = I_HWDATA[qdec_pkg::CMD_SRC_A_LSB +: SW];
    wire [SW-1:0] c_src_b = I_HWDATA[qdec_pkg::CMD_SRC_B_LSB +: SW];
    wire held = reserved_reg[slot];
    // opening a held slot, or acting on a free one, is refused
    wire cmd_bad = ~slot_ok | (c_open & held) | (~c_open & ~held);
    wire cmd_go = wr_command & ~cmd_bad;
    // error event from a refused command, select or timeout write
    wire err_event = (wr_command & cmd_bad) | (wr_select & ~new_sel_ok) | (wr_timeout & ~sel_ok);

    // ==========================================================
    // decoder instances
    qdec_pkg::dec_state_t dec_state [ND];
    logic [ND-1:0] stall_event;
    logic [ND-1:0] clear_pulse;

    generate
        for (genvar g = 0; g < ND; g++) begin : g_dec
            wire ph_a = pins_sync[src_a_reg[g]];
            wire ph_b = pins_sync[src_b_reg[g]];
            // reset command pulse for this slot
            assign clear_pulse[g] = cmd_go & c_reset & (slot == g);
            qdec_channel u_chan (
                .i_clk(I_CORE_CLK),
                .i_rst(I_RST),
                .i_phase_a(ph_a),
                .i_phase_b(ph_b),
                .i_run(run_reg[g]),
                .i_clear(clear_pulse[g]),
                .i_polarity(pol_reg[g]),
                .i_halt_timeout(halt_timeout_setting_reg[g]),
                .o_state(dec_state[g]),
                .o_stall_event(stall_event[g])
            );
        end
    endgenerate

    // ==========================================================
    // bus bookkeeping: remember a write for its data phase
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= take_wr & in_win;
            wr_addr_reg <= I_HADDR[7:0];
        end
    end

    // ==========================================================
    // slot reservation and run state
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            reserved_reg <= '0;
            run_reg <= '0;
            pol_reg <= '0;
        end else if (cmd_go) begin
            if (c_open) begin
                // reserve slot and latch its routing
                reserved_reg[slot] <= 1'b1;
                run_reg[slot] <= 1'b0;
                pol_reg[slot] <= c_pol;
            end else if (c_close) begin
                reserved_reg[slot] <= 1'b0;
                run_reg[slot] <= 1'b0;
            end else if (c_stop) begin
                run_reg[slot] <= 1'b0;
            end else if (c_start) begin
                run_reg[slot] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // source routing and halt timeouts, one entry per slot
    generate
        for (genvar s = 0; s < ND; s++) begin : g_cfg
            always_ff @(posedge I_CORE_CLK) begin
                if (I_RST) begin
                    src_a_reg[s] <= '0;
                    src_b_reg[s] <= '0;
                    halt_timeout_setting_reg[s] <= qdec_pkg::HALT_TIMEOUT_RST;
                end else begin
                    if (cmd_go && c_open && slot == s) begin
                        src_a_reg[s] <= c_src_a;
                        src_b_reg[s] <= c_src_b;
                    end
                    if (wr_timeout && sel_ok && select_reg[2:0] == s) begin
                        halt_timeout_setting_reg[s] <= I_HWDATA;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // read selection and error flag
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            select_reg <= qdec_pkg::SELECT_RST;
            cmd_err_reg <= 1'b0;
        end else begin
            if (wr_select) begin
                select_reg <= I_HWDATA[3:0];
            end
            // error shows the result of the latest command, select or timeout write
            if (wr_command || wr_select || wr_timeout) begin
                cmd_err_reg <= err_event;
            end
        end
    end

    // ==========================================================
    // interrupt status: read clears, a new event in that cycle wins
    wire [8:0] int_set = {err_event, stall_event};
    wire rd_status = take_rd & in_win & (rd_ofs == qdec_pkg::OFS_INT_STATUS);
    wire [8:0] int_clr = rd_status ? 9'h1FF : 9'h000;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            int_status_reg <= '0;
            int_mask_reg <= qdec_pkg::INT_MASK_RST;
        end else begin
            int_status_reg <= (int_status_reg & ~int_clr) | int_set;
            if (wr_int_mask) begin
                int_mask_reg <= I_HWDATA[8:0];
            end
        end
    end

    // writes to the status register are ignored; only reads clear it
    wire unused_wr = wr_int_status;

    // ==========================================================
    // read data mux; invalid selection reads zero state
    qdec_pkg::dec_state_t sel_state;
    assign sel_state = sel_ok ? dec_state[select_reg[2:0]] : '0;
    wire [31:0] sel_timeout = sel_ok ? halt_timeout_setting_reg[select_reg[2:0]] : 32'h0000_0000;
    wire [31:0] flags_word = {28'h0000000, reserved_reg[select_reg[2:0]] & sel_ok,
                              run_reg[select_reg[2:0]] & sel_ok, sel_state.stalled, sel_state.dir};
    wire [31:0] cmd_status_word = {8'h00, run_reg, reserved_reg, 7'h00, cmd_err_reg};
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (!in_win) begin
            rd_word = 32'h0000_0000;
        end else if (rd_ofs == qdec_pkg::OFS_INT_STATUS) begin
            rd_word = {23'h000000, int_status_reg};
        end else if (rd_ofs == qdec_pkg::OFS_INT_MASK) begin
            rd_word = {23'h000000, int_mask_reg};
        end else if (rd_ofs == qdec_pkg::OFS_CMD_STATUS) begin
            rd_word = cmd_status_word;
        end else if (rd_ofs == qdec_pkg::OFS_SELECT) begin
            rd_word = {28'h0000000, select_reg};
        end else if (rd_ofs == qdec_pkg::OFS_COUNT) begin
            rd_word = sel_state.count;
        end else if (rd_ofs == qdec_pkg::OFS_PERIOD) begin
            rd_word = sel_state.period;
        end else if (rd_ofs == qdec_pkg::OFS_FLAGS) begin
            rd_word = flags_word;
        end else if (rd_ofs == qdec_pkg::OFS_HALT_TIMEOUT) begin
            rd_word = sel_timeout;
        end
    end

    // ==========================================================
    // read data register, loaded when the read is taken
    // zero wait states; a read straight after a write sees pre-write data
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (take_rd) begin
            hrdata_reg <= rd_word;
        end
    end

    // ==========================================================
    // outputs
    assign O_HRDATA = hrdata_reg;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;
    assign O_IRQ = |(int_status_reg & int_mask_reg);
endmodule : quad_decoder_4x

/* File: testbench/quad_decoder_4x_checker.sv */
// concurrent checks on the bus and interrupt ports of the decoder bank
// assumes one master doing single word transfers; bound to every instance
`timescale 1ns/1ps
module quad_decoder_4x_checker (
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    // bus as seen at the slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    input wire logic [31:0] O_HRDATA,
    input wire logic O_HREADYOUT,
    input wire logic O_HRESP,
    // interrupt
    input wire logic O_IRQ
);
    // ==========================================================
    // helper decode of taken address phases
    wire take = I_HSEL && I_HTRANS[1] && I_HREADY;
    wire rd_take = take && !I_HWRITE;
    logic wr_mask_reg; // data phase of a mask write
    logic wr_cmd_reg; // data phase of a command write
    logic [8:0] mask_reg; // shadow of the interrupt mask
    logic mask_zero_reg; // mask was already zero a cycle ago
    wire bad_cmd = wr_cmd_reg && I_HREADY && (I_HWDATA[3:0] > 4'h7);
    // shadow follows the slave's write timing; the extra history bit allows a registered irq
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            wr_mask_reg <= 1'b0;
            wr_cmd_reg <= 1'b0;
            mask_reg <= 9'h000;
            mask_zero_reg <= 1'b1;
        end else begin
            if (I_HREADY) begin
                wr_mask_reg <= take && I_HWRITE && (I_HADDR == 32'h0000_0004);
                wr_cmd_reg <= take && I_HWRITE && (I_HADDR == 32'h0000_0008);
            end
            if (wr_mask_reg && I_HREADY) begin
                mask_reg <= I_HWDATA[8:0];
            end
            mask_zero_reg <= (mask_reg == 9'h000);
        end
    end
    // ==========================================================
    // assertions
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    hreadyout_one_a: assert property (O_HREADYOUT == 1'b1) else $error("wait state seen");
    hresp_okay_a: assert property (O_HRESP == 1'b0) else $error("bus error response");
    reset_quiet_a: assert property (disable iff (1'b0) I_RST |=> (O_IRQ == 1'b0) && (O_HRDATA == 32'h0))
        else $error("outputs not quiet in reset");
    rdata_hold_a: assert property (!rd_take |=> $stable(O_HRDATA)) else $error("read data moved");
    unmapped_read_a: assert property (rd_take && (I_HADDR[31:8] != 24'h0) |=> O_HRDATA == 32'h0)
        else $error("unmapped read not zero");
    cmd_read_zero_a: assert property (rd_take && (I_HADDR == 32'h8) |=> O_HRDATA == 32'h0)
        else $error("command register readable");
    err_irq_a: assert property (bad_cmd && mask_reg[8] |-> ##[1:3] O_IRQ)
        else $error("bad slot raised no interrupt");
    irq_masked_a: assert property ((mask_reg == 9'h000) && mask_zero_reg |-> !O_IRQ)
        else $error("interrupt while fully masked");
    // main scenarios
    cover property (rd_take && (I_HADDR == 32'h14));
    cover property ($rose(O_IRQ));
    cover property (bad_cmd);
endmodule : quad_decoder_4x_checker

bind quad_decoder_4x quad_decoder_4x_checker chk (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_HSEL(I_HSEL),
    .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY),
    .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_IRQ(O_IRQ));

/* File: testbench/qdec_encoder_model.sv */
// behavioural rotary encoder driving one pair of phase pins
// assumes the bench requests one step per clock at most
`timescale 1ns/1ps
module qdec_encoder_model (
    // clock
    input wire logic i_clk,
    // step requests
    input wire logic i_step,
    input wire logic i_fwd,
    input wire logic i_jump,
    // phase pins
    output logic o_a,
    output logic o_b
);
    // ==========================================================
    // shaft position within one quadrature cycle
    logic [1:0] pos_reg = 2'h0;
    // single or double moves
    // a jump flips both phases at once, only when a scenario asks for it
    always_ff @(posedge i_clk) begin
        if (i_step) begin
            pos_reg <= pos_reg + (i_jump ? 2'h2 : (i_fwd ? 2'h1 : 2'h3));
        end
    end
    assign o_a = pos_reg[1] ^ pos_reg[0];
    assign o_b = pos_reg[1];
endmodule : qdec_encoder_model

/* File: testbench/tb_quad_decoder_4x.sv */
// self-checking bench for the eight-slot quadrature decoder bank
// assumes the checker binds itself; encoder e sits on pins 2e and 2e+1
`timescale 1ns/1ps
module tb_quad_decoder_4x;
    // ==========================================================
    // clock, bus and encoder signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic rd_phase = 1'b0; // a read data phase ends at the next edge
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic irq;
    wire [15:0] pins; // one encoder output drives each bit
    logic [7:0] step = 8'h0;
    logic fwd = 1'b1;
    logic jump = 1'b0;
    logic [31:0] exp_q[$]; // expected read data, oldest first
    logic [31:0] zero_a [10] = '{32'h0, 32'h4, 32'h8, 32'hC, 32'h10, 32'h14, 32'h18, 32'h1C, 32'h20, 32'h100};
    int failures = 0;
    int n_compared = 0;
    int seed = 57;
    int n;
    int cnt [8]; // expected count of each slot
    always #25 clk = ~clk;
    quad_decoder_4x #(.NUM_PINS(16)) dut (.I_CORE_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_PHASE_PINS(pins), .O_IRQ(irq));
    // eight encoders; steps are taken one encoder at a time so direction lines are shared
    for (genvar e = 0; e < 8; e++) begin : g_enc
        qdec_encoder_model enc (.i_clk(clk), .i_step(step[e]), .i_fwd(fwd), .i_jump(jump),
            .o_a(pins[2*e]), .o_b(pins[2*e+1]));
    end
    // ==========================================================
    // comparison and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            failures++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic report_and_stop;
        if (failures == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // watcher takes the oldest note whenever a read data phase completes
    always @(posedge clk) begin
        if (rd_phase && hready === 1'b1) begin
            check(hrdata, exp_q.pop_front());
        end
    end
    // ==========================================================
    // bus and encoder drivers
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_phase <= !w;
        do @(posedge clk); while (hready !== 1'b1);
        rd_phase <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        xfer(a, 1'b0, 32'h0);
    endtask : rd
    // one move, then room for the synchroniser and count update
    task automatic enc(input int e, input logic f, input logic j);
        @(posedge clk);
        step[e] <= 1'b1;
        fwd <= f;
        jump <= j;
        @(posedge clk);
        step[e] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : enc
    // irq is looked at away from the edge that may update it
    task automatic irq_is(input logic want);
        #1;
        check({31'h0, irq}, {31'h0, want});
    endtask : irq_is
    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (zero_a[k]) rd(zero_a[k], 32'h0);
        // refused commands: start on a free slot, open on slot eight
        wr(32'h04, 32'h100);
        wr(32'h08, 32'h400);
        rd(32'h0C, 32'h1);
        irq_is(1'b1);
        rd(32'h00, 32'h100);
        rd(32'h00, 32'h0);
        irq_is(1'b0);
        wr(32'h08, 32'h108);
        rd(32'h0C, 32'h1);
        wr(32'h04, 32'h0);
        rd(32'h00, 32'h100);
        // slot i takes encoder 7-i, polarity alternating, then started
        for (int i = 0; i < 8; i++) begin
            wr(32'h08, (32'(15 - 2 * i) << 24) | (32'(14 - 2 * i) << 20) | (32'(i % 2) << 16) | 32'h100 | 32'(i));
            wr(32'h08, 32'h400 | 32'(i));
        end
        rd(32'h0C, 32'h00FF_FF00);
        for (int e = 0; e < 8; e++) begin
            n = 1 + ($random(seed) & 7);
            cnt[7 - e] = ((7 - e) % 2) ? n : -n;
            repeat (n) enc(e, 1'b1, 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            wr(32'h10, 32'(i));
            rd(32'h14, 32'(cnt[i]));
            rd(32'h14, 32'(cnt[i]));
            rd(32'h1C, {28'h0, 4'hC | 4'(i % 2)});
        end
        // reverse moves on slot 0 around a double change
        wr(32'h10, 32'h0);
        enc(7, 1'b0, 1'b0);
        enc(7, 1'b0, 1'b1);
        enc(7, 1'b0, 1'b0);
        rd(32'h14, 32'(cnt[0] + 2));
        rd(32'h1C, 32'hD);
        // stopped slot ignores moves; reset count still works
        wr(32'h08, 32'h800);
        enc(7, 1'b1, 1'b0);
        rd(32'h14, 32'(cnt[0] + 2));
        wr(32'h08, 32'h1000);
        rd(32'h14, 32'h0);
        rd(32'h1C, 32'h9);
        // closing running slot 1 stops it
        wr(32'h08, 32'h201);
        enc(6, 1'b1, 1'b0);
        wr(32'h10, 32'h1);
        rd(32'h14, 32'(cnt[1]));
        rd(32'h0C, 32'h00FC_FD00);
        // period of ten cycles, then stall after twenty quiet cycles
        wr(32'h10, 32'h2);
        wr(32'h20, 32'h14);
        rd(32'h20, 32'h14);
        enc(5, 1'b1, 1'b0);
        repeat (4) @(posedge clk);
        enc(5, 1'b1, 1'b0);
        rd(32'h18, 32'hA);
        rd(32'h1C, 32'hC);
        repeat (30) @(posedge clk);
        rd(32'h1C, 32'hE);
        wr(32'h04, 32'h4);
        irq_is(1'b1);
        rd(32'h00, 32'h4);
        irq_is(1'b0);
        enc(5, 1'b1, 1'b0);
        rd(32'h1C, 32'hC);
        // let the watcher take the last read before the verdict; every note must be used
        @(posedge clk);
        check(32'(exp_q.size()), 32'h0);
        report_and_stop();
    end
    // watchdog far beyond the fewer than one thousand cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule : tb_quad_decoder_4x
